// File: rtl/port_pin_mux.sv
// Port1/port2 pin function select with APB register access
`timescale 1ns/1ps
`default_nettype none

module port_pin_mux (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Pin levels, asynchronous
  input  wire logic                    p1_0_pin_in,
  input  wire logic                    p1_1_pin_in,
  input  wire logic                    p2_0_pin_in,
  input  wire logic                    p2_1_pin_in,
  input  wire logic                    bus_rx_in,
  // General-purpose drives from the data registers
  input  wire pinmux_pkg::pin_drive_t  p1_0_gpio,
  input  wire pinmux_pkg::pin_drive_t  p1_1_gpio,
  input  wire pinmux_pkg::pin_drive_t  p2_0_gpio,
  input  wire pinmux_pkg::pin_drive_t  p2_1_gpio,
  // On-chip peripherals, same clock
  input  wire logic                    uart_txd,
  input  wire logic                    serial_test_interface_data,
  input  wire logic                    diag_tx_pad,
  // Pin drives
  output pinmux_pkg::pin_drive_t       p1_0_drive,
  output pinmux_pkg::pin_drive_t       p1_1_drive,
  output pinmux_pkg::pin_drive_t       p2_0_drive,
  output pinmux_pkg::pin_drive_t       p2_1_drive,
  output pinmux_pkg::pin_drive_t       test_out_drive,
  // Internal destinations
  output logic      [3:0]              gpio_pin_level,
  output logic                         uart_rxd,
  output logic                         bus_tx,
  output logic                         bus_sync_rx,
  output logic                         diag_rx_pad
);

  // ***************************************************************
  // Input synchronisation
  // ***************************************************************
  pinmux_pkg::pin_sample_t smp;

  sync_2ff #(
    .WIDTH     (pinmux_pkg::SYNC_WIDTH),
    .RESET_VAL (5'h1f)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({p1_0_pin_in, p1_1_pin_in, p2_0_pin_in, p2_1_pin_in, bus_rx_in}),
    .sync_out (smp)
  );

  // ***************************************************************
  // APB slave
  // ***************************************************************
  logic [31:0] p1_fn_q;
  logic [31:0] p2_fn_q;
  logic        access;
  logic        done;
  logic        hit_p1;
  logic        hit_p2;
  logic [31:0] rd_mux;

  assign access = psel && penable;
  assign done   = access && pready;
  assign hit_p1 = (paddr == pinmux_pkg::PORT1_PIN_FUNCTION_ADDR);
  assign hit_p2 = (paddr == pinmux_pkg::PORT2_PIN_FUNCTION_ADDR);

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (hit_p1)
      rd_mux = p1_fn_q;
    else if (hit_p2)
      rd_mux = p2_fn_q;
  end

  // One wait state keeps every bus output registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= access && !pready;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (access && !pready)
    begin
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= !(hit_p1 || hit_p2);
    end
    else
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // ***************************************************************
  // Function registers
  // ***************************************************************
  // Reserved bits are dropped, so a careless write cannot set them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      p1_fn_q <= pinmux_pkg::PORT1_PIN_FUNCTION_RESET;
    else if (done && pwrite && hit_p1)
      p1_fn_q <= pwdata & pinmux_pkg::PORT1_DEFINED_MASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      p2_fn_q <= pinmux_pkg::PORT2_PIN_FUNCTION_RESET;
    else if (done && pwrite && hit_p2)
      p2_fn_q <= pwdata & pinmux_pkg::PORT2_DEFINED_MASK;
  end

  // ***************************************************************
  // Port1 pins
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p1_0_drive <= '0;
      p1_1_drive <= '0;
    end
    else
    begin
      // Receive function: pin is an input only
      p1_0_drive <= p1_fn_q[pinmux_pkg::P1_UART_RX_BIT] ? '0 : p1_0_gpio;
      p1_1_drive <= p1_fn_q[pinmux_pkg::P1_UART_TX_BIT]
                    ? pinmux_pkg::pin_drive_t'{o: uart_txd, oe: 1'b1}
                    : p1_1_gpio;
    end
  end

  // ***************************************************************
  // Port2 pins and test output
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p2_0_drive <= '0;
      p2_1_drive <= '0;
    end
    else
    begin
      // Pass-through input: the outside party drives this pin
      p2_0_drive <= p2_fn_q[pinmux_pkg::P2_PASS_TX_BIT] ? '0 : p2_0_gpio;
      p2_1_drive <= p2_fn_q[pinmux_pkg::P2_PASS_RX_BIT]
                    ? pinmux_pkg::pin_drive_t'{o: smp.bus_rx, oe: 1'b1}
                    : p2_1_gpio;
    end
  end

  // Test data never reaches the pin with the gate clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      test_out_drive <= '0;
    else if (p2_fn_q[pinmux_pkg::P2_TEST_OUT_BIT])
      test_out_drive <= '{o: serial_test_interface_data, oe: 1'b1};
    else
      test_out_drive <= '0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gpio_pin_level <= 4'h0;
    else
      gpio_pin_level <= {smp.p2_1, smp.p2_0, smp.p1_1, smp.p1_0};
  end

  // ***************************************************************
  // Bus transmit path
  // ***************************************************************
  // Pass-through wins so the transceiver can run without the core
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_tx <= pinmux_pkg::SERIAL_IDLE;
    else if (p2_fn_q[pinmux_pkg::P2_PASS_TX_BIT])
      bus_tx <= smp.p2_0;
    else if (p2_fn_q[pinmux_pkg::P2_BUS_TX_BIT])
      bus_tx <= uart_txd;
    else
      bus_tx <= diag_tx_pad;
  end

  // ***************************************************************
  // Bus receive path
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_sync_rx <= pinmux_pkg::SERIAL_IDLE;
    else if (p2_fn_q[pinmux_pkg::P2_BUS_RX_BIT])
      bus_sync_rx <= smp.bus_rx;
    else
      bus_sync_rx <= pinmux_pkg::SERIAL_IDLE;
  end

  // Bus receive takes the UART over port1 when both are selected
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      uart_rxd <= pinmux_pkg::SERIAL_IDLE;
    else if (p2_fn_q[pinmux_pkg::P2_BUS_RX_BIT])
      uart_rxd <= smp.bus_rx;
    else if (p1_fn_q[pinmux_pkg::P1_UART_RX_BIT])
      uart_rxd <= smp.p1_0;
    else
      uart_rxd <= pinmux_pkg::SERIAL_IDLE;
  end

  // Readback pad has no pin; it always mirrors the bus level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      diag_rx_pad <= pinmux_pkg::SERIAL_IDLE;
    else
      diag_rx_pad <= smp.bus_rx;
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  chk_p1_tx_route: assert property (
    p1_fn_q[pinmux_pkg::P1_UART_TX_BIT]
    |=> p1_1_drive.oe && p1_1_drive.o == $past(uart_txd))
    else $error("port1 transmit pin not driven by uart");

  chk_p1_rx_route: assert property (
    !p2_fn_q[pinmux_pkg::P2_BUS_RX_BIT] && p1_fn_q[pinmux_pkg::P1_UART_RX_BIT]
    |=> uart_rxd == $past(smp.p1_0) && !p1_0_drive.oe)
    else $error("port1 receive pin not fed to uart");

  chk_p2_reset_value: assert property (
    $rose(presetn) |-> p2_fn_q == pinmux_pkg::PORT2_PIN_FUNCTION_RESET)
    else $error("port2 function register reset value wrong");

  // Write, one idle cycle, then read of the same register
  chk_write_readback: assert property (
    done && pwrite && hit_p2 ##1 !psel ##1 psel && !penable && !pwrite && hit_p2
    ##1 penable ##1 pready
    |-> prdata == ($past(pwdata, 4) & pinmux_pkg::PORT2_DEFINED_MASK))
    else $error("port2 readback differs from write");

  // Reset release edge still loads reset drives, so start past it
  chk_test_gate: assert property (
    presetn |-> if (p2_fn_q[pinmux_pkg::P2_TEST_OUT_BIT])
      ##1 (test_out_drive.oe && test_out_drive.o == $past(serial_test_interface_data))
    else
      ##1 (test_out_drive == '0))
    else $error("test output gating wrong");

  chk_bus_tx_uart: assert property (
    p2_fn_q[pinmux_pkg::P2_BUS_TX_BIT] && !p2_fn_q[pinmux_pkg::P2_PASS_TX_BIT]
    |=> bus_tx == $past(uart_txd))
    else $error("bus transmit not from uart");

  chk_bus_tx_pad: assert property (
    !p2_fn_q[pinmux_pkg::P2_BUS_TX_BIT] && !p2_fn_q[pinmux_pkg::P2_PASS_TX_BIT]
    |=> bus_tx == $past(diag_tx_pad))
    else $error("bus transmit not from pad bit");

  chk_bus_rx_both: assert property (
    p2_fn_q[pinmux_pkg::P2_BUS_RX_BIT]
    |=> bus_sync_rx == $past(smp.bus_rx) && uart_rxd == bus_sync_rx)
    else $error("bus receive not delivered to both");

  chk_bus_rx_block: assert property (
    !p2_fn_q[pinmux_pkg::P2_BUS_RX_BIT]
    |=> bus_sync_rx == pinmux_pkg::SERIAL_IDLE && diag_rx_pad == $past(smp.bus_rx))
    else $error("bus receive not blocked or readback lost");

  chk_pass_rx_pin: assert property (
    p2_fn_q[pinmux_pkg::P2_PASS_RX_BIT]
    |=> p2_1_drive.oe && p2_1_drive.o == $past(smp.bus_rx))
    else $error("bus receive not on port2 pin");

  chk_pass_tx_pin: assert property (
    p2_fn_q[pinmux_pkg::P2_PASS_TX_BIT] [*4]
    |-> bus_tx == $past(p2_0_pin_in, 3) && !p2_0_drive.oe)
    else $error("port2 pin not passed to bus");

  chk_apb_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

endmodule

`default_nettype wire

// File: rtl/pinmux_pkg.sv
// Package: register map, field positions and carriers of the port function mux
//
// Overview of operation
// - Port1 bit 4 drives UART transmit on pin
// - Port1 bit 0 feeds pin to UART receive unless port2 bit 16 set
// - Port2 register at 0xffff0d08, resets 0x01000000
// - Port2 bit 24 gates test data to pin
// - Port2 bit 20 sends UART transmit to bus unless bit 0 set
// - Bits 20 and 0 clear: bus transmit from pad bit
// - Bit 16 feeds bus receive to sync, UART
// - Bit 16 clear blocks receive; pad reads back
// - Port2 bit 4 drives bus receive on pin
// - Port2 bit 0 passes pin onto bus
// - Bits 4 and 0 give standalone transceiver
// - Diagnostic pads are internal signals only

package pinmux_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [31:0] PORT1_PIN_FUNCTION_ADDR  = 32'hffff0d04;
  localparam logic [31:0] PORT2_PIN_FUNCTION_ADDR  = 32'hffff0d08;
  localparam logic [31:0] PORT1_PIN_FUNCTION_RESET = 32'h00000000;
  localparam logic [31:0] PORT2_PIN_FUNCTION_RESET = 32'h01000000;
  localparam logic [31:0] PORT1_DEFINED_MASK       = 32'h00000011;
  localparam logic [31:0] PORT2_DEFINED_MASK       = 32'h01110011;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int P1_UART_RX_BIT  = 0;
  localparam int P1_UART_TX_BIT  = 4;
  localparam int P2_PASS_TX_BIT  = 0;
  localparam int P2_PASS_RX_BIT  = 4;
  localparam int P2_BUS_RX_BIT   = 16;
  localparam int P2_BUS_TX_BIT   = 20;
  localparam int P2_TEST_OUT_BIT = 24;

  // ***************************************************************
  // Levels and carriers
  // ***************************************************************
  localparam logic SERIAL_IDLE = 1'b1;
  localparam int   SYNC_WIDTH  = 5;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;

  typedef struct packed {
    logic p1_0;
    logic p1_1;
    logic p2_0;
    logic p2_1;
    logic bus_rx;
  } pin_sample_t;

endpackage

// File: rtl/sync_2ff.sv
// Two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
  parameter int          WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage is read by the second stage only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: verification/periph_model.sv
// Model of the on-chip UART, test interface, pad write and transceiver bus
`timescale 1ns/1ps
`default_nettype none

module periph_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] levels,
  input  wire logic       bus_tx,
  output logic            uart_txd,
  output logic            serial_test_interface_data,
  output logic            diag_tx_pad,
  output logic            bus_rx_in
);
  logic bus_ext_q;

  // Peripherals launch on the system clock, idle high out of reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {uart_txd, serial_test_interface_data, diag_tx_pad, bus_ext_q} <= 4'hf;
    else
      {uart_txd, serial_test_interface_data, diag_tx_pad, bus_ext_q} <= levels;
  end

  // Wired-and bus: recessive high, so the receiver sees our own transmit too
  assign bus_rx_in = bus_tx & bus_ext_q;
endmodule

`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the port pin function mux
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, r, seed, c1, c2;
  logic p1_0_pin_in, p1_1_pin_in, p2_0_pin_in, p2_1_pin_in, bus_rx_in;
  logic uart_txd, serial_test_interface_data, diag_tx_pad, rx, tx;
  logic uart_rxd, bus_tx, bus_sync_rx, diag_rx_pad;
  logic [3:0] lv, gpio_pin_level;
  pinmux_pkg::pin_drive_t p1_0_gpio, p1_1_gpio, p2_0_gpio, p2_1_gpio;
  pinmux_pkg::pin_drive_t p1_0_drive, p1_1_drive, p2_0_drive, p2_1_drive, test_out_drive;
  int err_total, num_checks;

  port_pin_mux dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .p1_0_pin_in, .p1_1_pin_in, .p2_0_pin_in, .p2_1_pin_in, .bus_rx_in,
    .p1_0_gpio, .p1_1_gpio, .p2_0_gpio, .p2_1_gpio, .uart_txd, .serial_test_interface_data,
    .diag_tx_pad, .p1_0_drive, .p1_1_drive, .p2_0_drive, .p2_1_drive, .test_out_drive,
    .gpio_pin_level, .uart_rxd, .bus_tx, .bus_sync_rx, .diag_rx_pad);

  periph_model pm (.pclk, .presetn, .levels(lv), .bus_tx, .uart_txd,
    .serial_test_interface_data, .diag_tx_pad, .bus_rx_in);

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Slave answer time is not assumed; only the count bounds a hang
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check("apb answer", 32'(n < 40), 32'h1);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check_paths;
    tx = p2_0_pin_in;
    if (!c2[0])
      tx = c2[20] ? lv[3] : lv[1];
    rx = tx & lv[0];
    check("bus_tx", 32'(bus_tx), 32'(tx));
    check("bus_sync_rx", 32'(bus_sync_rx), 32'(c2[16] ? rx : 1'b1));
    check("uart_rxd", 32'(uart_rxd), 32'(c2[16] ? rx : c1[0] ? p1_0_pin_in : 1'b1));
    check("diag_rx_pad", 32'(diag_rx_pad), 32'(rx));
    check("p1_1_drive", 32'(p1_1_drive), 32'(c1[4] ? {lv[3], 1'b1} : p1_1_gpio));
    check("p1_0_drive", 32'(p1_0_drive), 32'(c1[0] ? 2'b00 : p1_0_gpio));
    check("p2_1_drive", 32'(p2_1_drive), 32'(c2[4] ? {rx, 1'b1} : p2_1_gpio));
    check("p2_0_drive", 32'(p2_0_drive), 32'(c2[0] ? 2'b00 : p2_0_gpio));
    check("test_out", 32'(test_out_drive), 32'(c2[24] ? {lv[2], 1'b1} : 2'b00));
    check("gpio_pin_level", 32'(gpio_pin_level),
      32'({p2_1_pin_in, p2_0_pin_in, p1_1_pin_in, p1_0_pin_in}));
  endtask

  // ***************************************************************
  // Clock, watchdog and tests
  // ***************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial
  begin
    #500us;
    err_total++;
    final_report();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, c1, c2} = '0;
    {p1_0_pin_in, p1_1_pin_in, p2_0_pin_in, p2_1_pin_in, lv} = '1;
    {p1_0_gpio, p1_1_gpio, p2_0_gpio, p2_1_gpio} = '0;
    err_total = 0;
    num_checks = 0;
    seed = 32'h9b8d2b2f;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pinmux_pkg::PORT2_PIN_FUNCTION_ADDR, '0);
    check("port2 reset", r, 32'h01000000);
    check("port2 no error", 32'(e), 32'h0);
    apb(1'b0, pinmux_pkg::PORT1_PIN_FUNCTION_ADDR, '0);
    check("port1 reset", r, pinmux_pkg::PORT1_PIN_FUNCTION_RESET);
    apb(1'b1, 32'hffff0d0c, '1);
    check("unmapped error", 32'(e), 32'h1);
    apb(1'b0, 32'hffff0d0c, '0);
    check("unmapped read data", r, 32'h00000000);
    check("unmapped read error", 32'(e), 32'h1);
    apb(1'b1, pinmux_pkg::PORT2_PIN_FUNCTION_ADDR, '1);
    apb(1'b0, pinmux_pkg::PORT2_PIN_FUNCTION_ADDR, '0);
    check("port2 defined bits", r, 32'h01110011);
    $display("test registers done");
    // Every select combination; reserved bits written as zero
    for (int i = 0; i < 128; i++)
    begin
      c1 = 32'({i[1], 3'b000, i[0]});
      c2 = 32'({i[6], 3'b000, i[5], 3'b000, i[4], 11'h000, i[3], 3'b000, i[2]});
      apb(1'b1, pinmux_pkg::PORT1_PIN_FUNCTION_ADDR, c1);
      apb(1'b1, pinmux_pkg::PORT2_PIN_FUNCTION_ADDR, c2);
      apb(1'b0, pinmux_pkg::PORT2_PIN_FUNCTION_ADDR, '0);
      check("port2 readback", r, c2);
      apb(1'b0, pinmux_pkg::PORT1_PIN_FUNCTION_ADDR, '0);
      check("port1 readback", r, c1);
      repeat (16) seed = lfsr(seed);
      lv <= seed[3:0];
      {p2_1_pin_in, p2_0_pin_in, p1_1_pin_in, p1_0_pin_in} <= seed[7:4];
      {p1_0_gpio, p1_1_gpio, p2_0_gpio, p2_1_gpio} <= seed[15:8];
      repeat (8) @(posedge pclk);
      check_paths();
    end
    $display("test routing done");
    // Reset in mid-run with routing selected: defaults must come back
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check("bus_tx in reset", 32'(bus_tx), 32'(pinmux_pkg::SERIAL_IDLE));
    presetn <= 1'b1;
    c1 = pinmux_pkg::PORT1_PIN_FUNCTION_RESET;
    c2 = pinmux_pkg::PORT2_PIN_FUNCTION_RESET;
    apb(1'b0, pinmux_pkg::PORT2_PIN_FUNCTION_ADDR, '0);
    check("port2 after reset", r, c2);
    apb(1'b0, pinmux_pkg::PORT1_PIN_FUNCTION_ADDR, '0);
    check("port1 after reset", r, c1);
    repeat (8) @(posedge pclk);
    check_paths();
    $display("test mid-run reset done");
    final_report();
  end
endmodule

`default_nettype wire
